// ===== ft_failure_transfer.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "ft_regs.svh"
// Overview of operation
// - Input one break fails when input one used
// - Input two break fails when input two used
// - Converter fault always enters failure mode
// - Transfer outputs at power start, fail, manual, calibration
// - Proportional output one holds averaged level
// - Proportional output one drives fixed percentage
// - On-off output one forced by acting direction
// - Cooling output two holds averaged level
// - Cooling output two drives fixed percentage
// - Alarms transfer only on failure mode
// - Loop-break or sensor-fail alarm forced on
// - Dwell timer alarm ignores failure mode
// - Output two hold only when cooling
// - Hold runs open loop on averaged levels
// - Self-tune starts on enable, stores, then clears
// - Self-tune disabled by listed conditions immediately
// - Step direction kept if improved, else reversed
// - Control continues, setpoint change does not abort
// - Auto-tune allowed, seeds self-tune gains
// - Sensor-fail alarm activates at failure entry
module ft_failure_transfer #(
  parameter int unsigned POWER_START_CYCLES =
    32'(64'd1_000_000 * 64'(`FT_POWER_START_MS) / 64'(`FT_CLK_PERIOD_NS))
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire ft_pkg::ft_bus_req_t bus_req,
  output logic [15:0]             bus_rdata,
  input  wire ft_pkg::ft_errors_t  errors,
  input  wire ft_pkg::ft_modes_t   modes,
  input  wire ft_pkg::ft_tune_ev_t tune_ev,
  input  wire logic               event_input,
  input  wire logic [9:0]         out_one_drive_level,
  input  wire logic [9:0]         out_two_drive_level,
  input  wire logic               out_one_switch_in,
  input  wire logic [1:0]         alarm_in,
  output logic [9:0]              out_one_level,
  output logic                    out_one_switch,
  output logic [9:0]              out_two_level,
  output logic [1:0]              alarm_out,
  output logic                    failure_mode,
  output logic                    open_loop,
  output logic                    selftune_run,
  output logic                    selftune_store,
  output logic                    store_set_sel,
  output logic                    selftune_seed,
  output logic                    step_dir
);
  import ft_pkg::*;

  localparam int CW = $clog2(POWER_START_CYCLES + 1);

  // Software settings
  logic [15:0] cfg_q;              // Sources, actions, self enable
  logic [15:0] ft1_q;              // Output one fail setting
  logic [15:0] ft2_q;              // Output two fail setting
  logic [15:0] alarm_q;            // Alarm fail states and functions
  logic [15:0] prop_band_q;        // Proportional band
  logic [15:0] integral_time_q;    // Integral time
  // Internal state
  logic [CW-1:0] pwr_cnt_q;        // Power start countdown
  logic          pwr_start;        // Inside power start window
  logic          fail_d;           // Failure condition now
  logic          transfer_d;       // Transfer condition now
  logic [13:0]   avg_q [2];        // Averages, four fraction bits
  logic [9:0]    hold [2];         // Averaged levels, integer part
  logic [9:0]    drive [2];        // Live drive levels
  ft_pv_src_t    pv_src;           // Process value source
  ft_sp_src_t    sp_src;           // Setpoint source
  ft_alarm_fn_t  al_fn [2];        // Alarm functions
  logic [1:0]    al_state;         // Alarm preset fail states
  logic          st_gate_off;      // Self-tune inhibited
  logic [9:0]    fix1;             // Clamped fixed levels
  logic [9:0]    fix2;

  typedef enum logic {ST_IDLE, ST_RUN} ft_st_state_t;
  ft_st_state_t st_q;              // Self-tune sequencer state

  assign pv_src      = ft_pv_src_t'(cfg_q[`FT_CFG_PV_LSB +: 2]);
  assign sp_src      = ft_sp_src_t'(cfg_q[`FT_CFG_SP_LSB +: 2]);
  assign al_fn[0]    = ft_alarm_fn_t'(alarm_q[`FT_AL1_FN_LSB +: 2]);
  assign al_fn[1]    = ft_alarm_fn_t'(alarm_q[`FT_AL2_FN_LSB +: 2]);
  assign al_state    = {alarm_q[`FT_AL2_STATE], alarm_q[`FT_AL1_STATE]};
  assign drive[0]    = out_one_drive_level;
  assign drive[1]    = out_two_drive_level;
  assign pwr_start   = (pwr_cnt_q != '0);

  // Fixed settings above full scale are clamped to full scale
  assign fix1 = (ft1_q[9:0] > `FT_LEVEL_MAX) ? `FT_LEVEL_MAX : ft1_q[9:0];
  assign fix2 = (ft2_q[9:0] > `FT_LEVEL_MAX) ? `FT_LEVEL_MAX : ft2_q[9:0];

  // Failure detection from error flags and input usage
  always_comb begin
    fail_d = errors.converter_fault_error;
    if (errors.input_one_break_error && (pv_src != FT_PV_TWO || sp_src == FT_SP_ONE)) begin
      fail_d = 1'b1;
    end
    if (errors.input_two_break_error && (pv_src != FT_PV_ONE || sp_src == FT_SP_TWO)) begin
      fail_d = 1'b1;
    end
  end

  // Output transfer conditions
  assign transfer_d = pwr_start | fail_d | modes.manual | modes.calibration;

  // Power start window countdown
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_cnt_q <= CW'(POWER_START_CYCLES);
    end else if (pwr_start) begin
      pwr_cnt_q <= pwr_cnt_q - CW'(1);
    end
  end

  // Running average per output, frozen during transfer
  for (genvar i = 0; i < 2; i++) begin : g_avg
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        avg_q[i] <= 14'h0000;
      end else if (!transfer_d) begin
        // Exponential average, weight one sixteenth
        avg_q[i] <= avg_q[i] - {4'h0, avg_q[i][13:4]} + {4'h0, drive[i]};
      end
    end
    assign hold[i] = avg_q[i][13:4];
  end

  // Output one drive
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_one_level  <= 10'h000;
      out_one_switch <= 1'b0;
    end else if (!transfer_d) begin
      // Normal closed loop
      out_one_level  <= out_one_drive_level;
      out_one_switch <= out_one_switch_in;
    end else if (prop_band_q == 16'h0000) begin
      // On-off control: off when reverse, on when direct
      out_one_level  <= 10'h000;
      out_one_switch <= cfg_q[`FT_CFG_DIRECT];
    end else if (ft1_q[`FT_FT_HOLD]) begin
      out_one_level  <= hold[0];
      out_one_switch <= 1'b0;
    end else begin
      out_one_level  <= fix1;
      out_one_switch <= 1'b0;
    end
  end

  // Output two drive, transfer only when cooling
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_two_level <= 10'h000;
    end else if (!transfer_d || !cfg_q[`FT_CFG_COOL]) begin
      out_two_level <= out_two_drive_level;
    end else if (ft2_q[`FT_FT_HOLD]) begin
      out_two_level <= hold[1];
    end else begin
      out_two_level <= fix2;
    end
  end

  // Status flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      failure_mode <= 1'b0;
      open_loop    <= 1'b0;
    end else begin
      failure_mode <= fail_d;
      open_loop    <= transfer_d;
    end
  end

  // Alarm transfer per alarm
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        alarm_out[i] <= 1'b0;
      end else if (!fail_d || al_fn[i] == FT_AL_DWELL_TIMER) begin
        // Power start, manual and calibration leave alarms alone
        alarm_out[i] <= alarm_in[i];
      end else if (al_fn[i] == FT_AL_LOOP_BREAK || al_fn[i] == FT_AL_SENSOR_FAIL) begin
        alarm_out[i] <= 1'b1;
      end else begin
        alarm_out[i] <= al_state[i];
      end
    end
  end

  // Self-tune inhibit conditions
  assign st_gate_off = !cfg_q[`FT_CFG_SELF] || prop_band_q == 16'h0000 ||
                       integral_time_q == 16'h0000 || modes.loop_break || fail_d ||
                       modes.manual || modes.sleep || modes.calibration;

  // Self-tune sequencer; setpoint changes have no effect here
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (!st_gate_off) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (st_gate_off || tune_ev.tune_done) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Self-tune outputs and step direction
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      selftune_run   <= 1'b0;
      selftune_store <= 1'b0;
      store_set_sel  <= 1'b0;
      selftune_seed  <= 1'b0;
      step_dir       <= 1'b0;
    end else begin
      selftune_run   <= (st_q == ST_RUN) && !st_gate_off && !tune_ev.tune_done;
      selftune_store <= (st_q == ST_RUN) && !st_gate_off && tune_ev.tune_done;
      selftune_seed  <= cfg_q[`FT_CFG_SELF] && tune_ev.autotune_done;
      if ((st_q == ST_RUN) && !st_gate_off && tune_ev.tune_done) begin
        store_set_sel <= event_input;
      end
      if ((st_q == ST_RUN) && tune_ev.cycle_done && !tune_ev.improved) begin
        step_dir <= ~step_dir;
      end
    end
  end

  // Register writes; a software write beats the hardware clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_q           <= `FT_CFG_RST;
      ft1_q           <= `FT_FT_RST;
      ft2_q           <= `FT_FT_RST;
      alarm_q         <= `FT_ALARM_RST;
      prop_band_q     <= `FT_PB_RST;
      integral_time_q <= `FT_TI_RST;
    end else begin
      if ((st_q == ST_RUN) && !st_gate_off && tune_ev.tune_done) begin
        cfg_q[`FT_CFG_SELF] <= 1'b0;
      end
      if (bus_req.wr) begin
        unique case (bus_req.addr)
          `FT_CFG_OFS:     cfg_q           <= bus_req.wdata;
          `FT_OUT1_FT_OFS: ft1_q           <= bus_req.wdata;
          `FT_OUT_TWO_FUNCTION_FT_OFS: ft2_q           <= bus_req.wdata;
          `FT_ALARM_OFS:   alarm_q         <= bus_req.wdata;
          `FT_PB_OFS:      prop_band_q     <= bus_req.wdata;
          `FT_TI_OFS:      integral_time_q <= bus_req.wdata;
          default: ;
        endcase
      end
    end
  end

  // Register reads, data one cycle later, unmapped reads zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `FT_CFG_OFS:     bus_rdata <= cfg_q;
        `FT_OUT1_FT_OFS: bus_rdata <= ft1_q;
        `FT_OUT_TWO_FUNCTION_FT_OFS: bus_rdata <= ft2_q;
        `FT_ALARM_OFS:   bus_rdata <= alarm_q;
        `FT_PB_OFS:      bus_rdata <= prop_band_q;
        `FT_TI_OFS:      bus_rdata <= integral_time_q;
        `FT_STATUS_OFS:  bus_rdata <= {11'h000, st_q == ST_RUN, pwr_start,
                                       transfer_d, fail_d, step_dir};
        `FT_HOLD1_OFS:   bus_rdata <= {6'h00, hold[0]};
        `FT_HOLD2_OFS:   bus_rdata <= {6'h00, hold[1]};
        default:         bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // Checks on failure detection
  a_conv_fault_fail: assert property (@(posedge clock) disable iff (sys_rst)
    errors.converter_fault_error |=> failure_mode)
    else $error("fault without failure");
  a_in1_break_fail: assert property (@(posedge clock) disable iff (sys_rst)
    errors.input_one_break_error && pv_src == FT_PV_ONE |=> failure_mode)
    else $error("input one break missed");
  a_in1_sp_fail: assert property (@(posedge clock) disable iff (sys_rst)
    errors.input_one_break_error && sp_src == FT_SP_ONE |=> failure_mode)
    else $error("setpoint input break missed");
  a_in2_break_fail: assert property (@(posedge clock) disable iff (sys_rst)
    errors.input_two_break_error && pv_src == FT_PV_DIFF_TWO_ONE |=> failure_mode)
    else $error("input two break missed");
  a_fail_clear: assert property (@(posedge clock) disable iff (sys_rst)
    !fail_d |=> !failure_mode)
    else $error("failure without cause");

  // Checks on transfer entry and the averages
  a_manual_open_loop: assert property (@(posedge clock) disable iff (sys_rst)
    modes.manual |=> open_loop)
    else $error("manual without transfer");
  a_calib_open_loop: assert property (@(posedge clock) disable iff (sys_rst)
    modes.calibration |=> open_loop)
    else $error("calibration without transfer");
  a_pwr_window: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(pwr_start) |-> $past(pwr_cnt_q) == CW'(1))
    else $error("window length");
  a_hold_frozen: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && $past(transfer_d) |-> $stable(avg_q[0]))
    else $error("average moved in transfer");
  a_closed_loop: assert property (@(posedge clock) disable iff (sys_rst)
    !transfer_d |=> out_one_level == $past(out_one_drive_level))
    else $error("closed loop level not passed");

  // Checks on the output overrides
  a_onoff_direct: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && prop_band_q == 16'h0000
    |=> out_one_switch == $past(cfg_q[`FT_CFG_DIRECT]))
    else $error("on-off state wrong");
  a_out1_hold: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && prop_band_q != 16'h0000 && ft1_q[`FT_FT_HOLD]
    |=> out_one_level == $past(hold[0]))
    else $error("output one not held");
  a_out1_fixed: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && prop_band_q != 16'h0000 && !ft1_q[`FT_FT_HOLD]
    |=> out_one_level == $past(fix1))
    else $error("output one not fixed");
  a_out_two_function_hold: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && cfg_q[`FT_CFG_COOL] && ft2_q[`FT_FT_HOLD]
    |=> out_two_level == $past(hold[1]))
    else $error("output two not held");
  a_out_two_function_fixed: assert property (@(posedge clock) disable iff (sys_rst)
    transfer_d && cfg_q[`FT_CFG_COOL] && !ft2_q[`FT_FT_HOLD]
    |=> out_two_level == $past(fix2))
    else $error("output two not fixed");
  a_out_two_function_no_cool: assert property (@(posedge clock) disable iff (sys_rst)
    !cfg_q[`FT_CFG_COOL] |=> out_two_level == $past(out_two_drive_level))
    else $error("output two transferred");

  // Checks on the alarm overrides
  a_alarm_no_fail: assert property (@(posedge clock) disable iff (sys_rst)
    !fail_d |=> alarm_out == $past(alarm_in))
    else $error("alarm transferred");
  a_alarm_preset: assert property (@(posedge clock) disable iff (sys_rst)
    fail_d && al_fn[1] == FT_AL_NORMAL |=> alarm_out[1] == $past(al_state[1]))
    else $error("alarm preset state wrong");
  a_alarm_forced: assert property (@(posedge clock) disable iff (sys_rst)
    fail_d && (al_fn[1] == FT_AL_LOOP_BREAK || al_fn[1] == FT_AL_SENSOR_FAIL)
    |=> alarm_out[1])
    else $error("alarm not forced on");
  a_alarm_sensor: assert property (@(posedge clock) disable iff (sys_rst)
    fail_d && al_fn[0] == FT_AL_SENSOR_FAIL |=> alarm_out[0])
    else $error("sensor alarm not on");
  a_dwell_alarm: assert property (@(posedge clock) disable iff (sys_rst)
    al_fn[0] == FT_AL_DWELL_TIMER |=> alarm_out[0] == $past(alarm_in[0]))
    else $error("dwell alarm transferred");

  // Checks on the self-tune gate
  a_self_gate: assert property (@(posedge clock) disable iff (sys_rst)
    st_gate_off |=> !selftune_run)
    else $error("self-tune not gated");
  a_run_idle: assert property (@(posedge clock) disable iff (sys_rst)
    st_q == ST_IDLE |=> !selftune_run)
    else $error("self-tune runs while idle");
  a_self_clear: assert property (@(posedge clock) disable iff (sys_rst)
    selftune_store && !$past(bus_req.wr) |-> !cfg_q[`FT_CFG_SELF])
    else $error("enable not cleared");
  a_store_sel: assert property (@(posedge clock) disable iff (sys_rst)
    selftune_store |-> store_set_sel == $past(event_input))
    else $error("parameter set not taken");
  a_step_reverse: assert property (@(posedge clock) disable iff (sys_rst)
    st_q == ST_RUN && tune_ev.cycle_done && !tune_ev.improved |=> step_dir != $past(step_dir))
    else $error("step direction kept");
  a_step_keep: assert property (@(posedge clock) disable iff (sys_rst)
    !(st_q == ST_RUN && tune_ev.cycle_done && !tune_ev.improved) |=> $stable(step_dir))
    else $error("step direction moved");
  a_seed_autotune: assert property (@(posedge clock) disable iff (sys_rst)
    cfg_q[`FT_CFG_SELF] && tune_ev.autotune_done |=> selftune_seed)
    else $error("seed not raised");

endmodule

// ===== ft_front_model.sv
`timescale 1ns/10ps
// Stand-in for the measurement front end and the control core
module ft_front_model (
  input  wire logic           clock,
  input  wire logic           sys_rst,
  input  wire logic [2:0]     fault_cmd,
  input  wire logic [9:0]     level_cmd,
  output ft_pkg::ft_errors_t  errors,
  output logic [9:0]          lvl_one,
  output logic [9:0]          lvl_two,
  output logic                sw_one
);
  import ft_pkg::*;
  // Error flags: bit2 input one, bit1 input two, bit0 converter
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errors <= '0;
    end else begin
      errors <= ft_errors_t'(fault_cmd);
    end
  end
  // Drive levels clamped to full scale, output two at half
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lvl_one <= 10'h000;
      lvl_two <= 10'h000;
      sw_one  <= 1'b0;
    end else begin
      lvl_one <= (level_cmd > 10'h03E8) ? 10'h03E8 : level_cmd;
      lvl_two <= lvl_one >> 1;
      sw_one  <= level_cmd[0];
    end
  end
endmodule

// ===== ft_pkg.sv
package ft_pkg;
  // Process value source selections
  typedef enum logic [1:0] {
    FT_PV_ONE, FT_PV_TWO, FT_PV_DIFF_ONE_TWO, FT_PV_DIFF_TWO_ONE
  } ft_pv_src_t;
  // Setpoint source selections
  typedef enum logic [1:0] {
    FT_SP_LOCAL, FT_SP_ONE, FT_SP_TWO, FT_SP_RSVD
  } ft_sp_src_t;
  // Alarm functions relevant to failure handling
  typedef enum logic [1:0] {
    FT_AL_NORMAL, FT_AL_LOOP_BREAK, FT_AL_SENSOR_FAIL, FT_AL_DWELL_TIMER
  } ft_alarm_fn_t;
  // Error flags from measurement front end
  typedef struct packed {
    logic input_one_break_error;
    logic input_two_break_error;
    logic converter_fault_error;
  } ft_errors_t;
  // Operating modes from the control core
  typedef struct packed {
    logic manual;
    logic calibration;
    logic sleep;
    logic loop_break;
  } ft_modes_t;
  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ft_bus_req_t;
  // Self-tune events from tuning core
  typedef struct packed {
    logic cycle_done;
    logic improved;
    logic tune_done;
    logic autotune_done;
  } ft_tune_ev_t;
endpackage

// ===== ft_regs.svh
`ifndef FT_REGS_SVH
`define FT_REGS_SVH

// Register offsets, byte addresses
`define FT_CFG_OFS      8'h00
`define FT_OUT1_FT_OFS  8'h04
`define FT_OUT_TWO_FUNCTION_FT_OFS  8'h08
`define FT_ALARM_OFS    8'h0C
`define FT_PB_OFS       8'h10
`define FT_TI_OFS       8'h14
`define FT_STATUS_OFS   8'h18
`define FT_HOLD1_OFS    8'h1C
`define FT_HOLD2_OFS    8'h20

// Config register fields
`define FT_CFG_PV_LSB   0
`define FT_CFG_SP_LSB   2
`define FT_CFG_DIRECT   4
`define FT_CFG_COOL     5
`define FT_CFG_SELF     6
// Fail setting fields
`define FT_FT_HOLD      15
// Alarm register fields
`define FT_AL1_STATE    0
`define FT_AL1_FN_LSB   1
`define FT_AL2_STATE    4
`define FT_AL2_FN_LSB   5

// Reset values
`define FT_CFG_RST      16'h0000
`define FT_FT_RST       16'h8000
`define FT_ALARM_RST    16'h0000
`define FT_PB_RST       16'h00B4
`define FT_TI_RST       16'h0064

// Full scale drive level, tenths of a percent
`define FT_LEVEL_MAX    10'h3E8
// Power start window and clock period
`define FT_POWER_START_MS 2500
`define FT_CLK_PERIOD_NS  50

`endif

// ===== tb.sv
`timescale 1ns/10ps
`include "ft_regs.svh"
// Self-checking bench for the failure transfer block
module tb;
  import ft_pkg::*;
  logic clock, sys_rst, ev_in, o1s, fm, ol, srun, sst, ssel, sseed, sdir, sw1, prv;
  ft_bus_req_t req;                     // Register bus request
  ft_modes_t   modes;                   // Operating modes
  ft_tune_ev_t tev;                     // Tuning events
  ft_errors_t  errs;                    // Error flags from model
  logic [15:0] d;                       // Read data seen
  logic [15:0] rdata;
  logic [9:0]  l1, l2, o1, o2, lvl, v;
  logic [2:0]  fault_cmd;
  logic [1:0]  al_in, al, ea;
  logic [7:0]  lf;                      // Random state
  int          n_fail, checks_done;
  logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30};
  logic [15:0] rv [7] = '{16'h0000, 16'h8000, 16'h8000, 16'h0000, 16'h00B4,
                          16'h0064, 16'h0000};

  ft_front_model ft_front_model_inst (.clock(clock), .sys_rst(sys_rst),
    .fault_cmd(fault_cmd), .level_cmd(lvl), .errors(errs), .lvl_one(l1),
    .lvl_two(l2), .sw_one(sw1));
  ft_failure_transfer #(.POWER_START_CYCLES(20)) ft_failure_transfer_inst (
    .clock(clock), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdata),
    .errors(errs), .modes(modes), .tune_ev(tev), .event_input(ev_in),
    .out_one_drive_level(l1), .out_two_drive_level(l2), .out_one_switch_in(sw1),
    .alarm_in(al_in), .out_one_level(o1), .out_one_switch(o1s), .out_two_level(o2),
    .alarm_out(al), .failure_mode(fm), .open_loop(ol), .selftune_run(srun),
    .selftune_store(sst), .store_set_sel(ssel), .selftune_seed(sseed),
    .step_dir(sdir));

  // Clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Comparison with counting
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait ran out
  task automatic give_up(logic ok);
    if (ok !== 1'b1) begin
      chk("wait", 16'h0000, 16'h0001);
      conclude();
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] wd);
    @(posedge clock);
    req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] q);
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 q = rdata;
  endtask
  // Random source
  function automatic logic [7:0] nxt(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Expected failure from errors and sources
  function automatic bit exp_fail(int pv, int sp, int e);
    return e[0] || (e[2] && (pv != 1 || sp == 1)) || (e[1] && (pv != 0 || sp == 2));
  endfunction
  // Pulse one tuning event for one cycle
  task automatic pulse(int k, logic imp);
    @(posedge clock);
    tev <= ft_tune_ev_t'(4'(8 >> k) | (imp ? 4'h4 : 4'h0));
    @(posedge clock);
    tev <= '0;
    #1;
  endtask

  initial begin
    sys_rst = 1'b1;
    req = '0;
    modes = '0;
    tev = '0;
    ev_in = 1'b0;
    fault_cmd = 3'h0;
    lvl = 10'h000;
    al_in = 2'h3;
    lf = 8'h50;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    tick(2);
    chk("open_loop", ol, 1);
    chk("alarm", al, al_in);
    // Reset values and unmapped read
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk("reg", d, rv[i]);
    end
    tick(20);
    chk("open_loop", ol, 0);
    // Failure entry for every error and source pairing except the reserved setpoint source
    for (int e = 1; e < 8; e = e * 2) begin
      for (int pv = 0; pv < 4; pv++) begin
        for (int sp = 0; sp < 3; sp++) begin
          wr(`FT_CFG_OFS, 16'(pv + 4 * sp));
          @(posedge clock);
          fault_cmd <= 3'(e);
          tick(3);
          chk("failure", fm, exp_fail(pv, sp, e));
          @(posedge clock);
          fault_cmd <= 3'h0;
        end
      end
    end
    // Averaged hold, then frozen while the level moves
    lf = nxt(lf);
    v = 10'(lf) * 10'h003;
    wr(`FT_CFG_OFS, 16'h0020);
    @(posedge clock);
    lvl <= v;
    tick(400);
    @(posedge clock);
    modes.manual <= 1'b1;
    tick(2);
    @(posedge clock);
    lvl <= ~v;
    tick(4);
    chk("out_one", o1, v);
    chk("out_two", o2, v >> 1);
    chk("open_loop", ol, 1);
    chk("alarm", al, al_in);
    rd(`FT_HOLD1_OFS, d);
    chk("hold_one", d, v);
    // Fixed values, one above full scale
    wr(`FT_OUT1_FT_OFS, {6'h00, v >> 2});
    wr(`FT_OUT_TWO_FUNCTION_FT_OFS, 16'h03FF);
    @(posedge clock);
    modes <= 4'h4;
    tick(3);
    chk("out_one", o1, v >> 2);
    chk("out_two", o2, 16'h03E8);
    wr(`FT_CFG_OFS, 16'h0000);
    tick(3);
    chk("out_two", o2, l2);
    // On-off output forced by acting direction
    wr(`FT_PB_OFS, 16'h0000);
    for (int dir = 0; dir < 2; dir++) begin
      wr(`FT_CFG_OFS, 16'(dir << 4));
      tick(3);
      chk("switch", o1s, dir);
      chk("out_one", o1, 0);
    end
    @(posedge clock);
    modes <= '0;
    wr(`FT_PB_OFS, 16'h00B4);
    // Alarm transfer for each alarm function
    for (int f = 0; f < 4; f++) begin
      lf = nxt(lf);
      @(posedge clock);
      al_in <= lf[1:0];
      wr(`FT_ALARM_OFS, 16'((f << 1) | 16 | (f << 5)));
      @(posedge clock);
      fault_cmd <= 3'h1;
      tick(3);
      ea[0] = (f == 3) ? lf[0] : (f != 0);
      ea[1] = (f == 3) ? lf[1] : 1'b1;
      chk("alarm", al, ea);
      @(posedge clock);
      fault_cmd <= 3'h0;
    end
    // Self-tune run, stepping, seeding and completion
    wr(`FT_CFG_OFS, 16'h0040);
    for (int i = 0; i < 8 && srun !== 1'b1; i++) tick(1);
    give_up(srun);
    prv = sdir;
    pulse(0, 1'b0);
    tick(2);
    chk("step_dir", sdir, !prv);
    pulse(0, 1'b1);
    tick(2);
    chk("step_dir", sdir, !prv);
    chk("run", srun, 1);
    pulse(3, 1'b0);
    for (int i = 0; i < 4 && sseed !== 1'b1; i++) tick(1);
    give_up(sseed);
    @(posedge clock);
    ev_in <= 1'b1;
    pulse(2, 1'b0);
    for (int i = 0; i < 4 && sst !== 1'b1; i++) tick(1);
    give_up(sst);
    chk("set_sel", ssel, 1);
    rd(`FT_CFG_OFS, d);
    chk("cfg", d, 16'h0000);
    // Each disabling condition stops a running self-tune
    for (int k = 0; k < 8; k++) begin
      wr(`FT_CFG_OFS, 16'h0040);
      for (int i = 0; i < 8 && srun !== 1'b1; i++) tick(1);
      give_up(srun);
      @(posedge clock);
      if (k < 4) modes <= 4'(8 >> k);
      if (k == 4) fault_cmd <= 3'h4;
      if (k == 5) wr(`FT_PB_OFS, 16'h0000);
      if (k == 6) wr(`FT_TI_OFS, 16'h0000);
      if (k == 7) wr(`FT_CFG_OFS, 16'h0000);
      tick(3);
      chk("run", srun, 0);
      @(posedge clock);
      modes <= '0;
      fault_cmd <= 3'h0;
      wr(`FT_PB_OFS, 16'h00B4);
      wr(`FT_TI_OFS, 16'h0064);
    end
    conclude();
  end
endmodule
